/* src/acs_params.svh */
/*
  Constants of the conversion sequencer: field widths, counts, full-scale code.
  Assumes inclusion by bare name from the sequencer files.
*/
`ifndef ACS_PARAMS_SVH
`define ACS_PARAMS_SVH

`define ACS_RES_W          10
`define ACS_RES_MAX        10'h3FF
`define ACS_CHAN_W         5
`define ACS_REF_W          3
`define ACS_CLOCK_DIVIDER_SELECT_W        3
`define ACS_SDLY_W         4
`define ACS_SLEN_W         5
`define ACS_ACC_W          3
`define ACS_ACCUM_W        16
`define ACS_DIV_W          9
`define ACS_SAMPLE_BASE    8'h02
`define ACS_CONV_BASE      8'h0D
`define ACS_CNT_W          8
`define ACS_START_EXTRA    9'h002

`endif

/* src/acs_pkg.sv */
/*
  Types of the conversion sequencer.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package acs_pkg;

  typedef enum logic [1:0]
  {
    ACS_IDLE  = 2'b00,
    ACS_WAIT  = 2'b01,
    ACS_CONV  = 2'b10
  } acs_state_t;

endpackage : acs_pkg

/* src/acs_prescaler.sv */
/*
  Prescaler for the converter clock: emits a one-cycle tick per converter
  clock rising edge. Assumes the parent holds run low while idle.
*/
`include "acs_params.svh"

module acs_prescaler
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      run,
  input  wire logic [`ACS_CLOCK_DIVIDER_SELECT_W-1:0]   clock_divider_select,
  output logic                           adc_tick
);

  logic [`ACS_DIV_W-1:0] count;
  logic [`ACS_DIV_W-1:0] next_count;
  logic [`ACS_DIV_W-1:0] last;

  // Division factor is 2 << select, so 2..256
  assign last = (`ACS_DIV_W'(2) << clock_divider_select) - `ACS_DIV_W'(1);

  always_comb
  begin
    next_count = count + `ACS_DIV_W'(1);
    if (!run || count == last)
    begin
      next_count = '0;
    end
  end

  // Tick one cycle past half period: with the take cycle and the state
  // change this gives the fixed start delay of factor/2 plus 2
  assign adc_tick = run && (count == (last >> 1) + `ACS_DIV_W'(1));

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      count <= '0;
    end
    else
    begin
      count <= next_count;
    end
  end

endmodule : acs_prescaler

/* src/acs_sequencer.sv */
/*
  Conversion sequencer of a 10-bit successive-approximation converter.
  Assumes control bits come from logic on sys_clk and the analog core
  answers with a settled comparator bit on each converter clock tick.
*/
// Notes on behaviour
// - Start write begins conversion; bit reads one meanwhile
// - Single mode clears start bit at completion
// - Channel change applies after running conversion
// - Accumulated or single result sets ready flag
// - Interrupt needs flag, enable and global enable
// - Flag set even with interrupt disabled
// - Event start enable lets events trigger
// - Edge event sets start bit, cleared at completion
// - Free run restarts right after each completion
// - Converter clock divided by selected prescaler
// - Prescaler runs with enable while busy, zero otherwise
// - Conversion begins next converter clock edge
// - Prescaler held idle; fixed start delay
// - Plain conversion lasts thirteen converter cycles
// - Sample capture two cycles after start
// - Ready flag clears on result read or write
// - Sampling lasts two plus delay plus length
// - Debug halt stops converter unless run_in_debug
// - Codes span zero to full scale 0x3FF
// - Result right-adjusted in result register
// - Selections locked during conversion, free last cycle
// - Free run continues only while start bit one
`include "acs_params.svh"

module acs_sequencer
(
  input  wire logic                      sys_clk,
  input  wire logic                      rst,
  input  wire logic                      enable,
  input  wire logic                      continuous_mode_bit,
  input  wire logic                      resolution_select,
  input  wire logic [`ACS_ACC_W-1:0]     accumulation_count,
  input  wire logic [`ACS_CLOCK_DIVIDER_SELECT_W-1:0]   clock_divider_select,
  input  wire logic [`ACS_SDLY_W-1:0]    sample_delay,
  input  wire logic [`ACS_SLEN_W-1:0]    sample_length,
  input  wire logic [`ACS_CHAN_W-1:0]    input_channel_select,
  input  wire logic [`ACS_REF_W-1:0]     reference_select,
  input  wire logic                      start_write,
  input  wire logic                      start_write_value,
  input  wire logic                      event_start_enable,
  input  wire logic                      event_in,
  input  wire logic                      result_ready_int_enable,
  input  wire logic                      global_int_enable,
  input  wire logic                      ready_clear_write,
  input  wire logic                      result_read,
  input  wire logic                      cpu_halted,
  input  wire logic                      run_in_debug,
  input  wire logic                      comparator_in,
  output logic                           start_conversion,
  output logic                           result_ready_flag,
  output logic                           result_ready_irq,
  output logic [`ACS_ACCUM_W-1:0]        result,
  output logic [`ACS_CHAN_W-1:0]         active_channel,
  output logic [`ACS_REF_W-1:0]          active_reference,
  output logic                           sample_hold,
  output logic [`ACS_RES_W-1:0]          sar_trial,
  output logic                           busy
);

  // ****************************************************************
  // Input conditioning
  // ****************************************************************
  // Comparator is analog, so two flip-flops precede any use
  logic cmp_meta;
  logic cmp_sync;
  logic event_prev;
  logic event_edge;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cmp_meta   <= 1'b0;
      cmp_sync   <= 1'b0;
      event_prev <= 1'b0;
    end
    else
    begin
      cmp_meta   <= comparator_in;
      cmp_sync   <= cmp_meta;
      event_prev <= event_in;
    end
  end

  // Event line is on sys_clk, so one register is enough for the edge
  assign event_edge = event_in && !event_prev;

  // ****************************************************************
  // Converter clock
  // ****************************************************************
  logic running;
  logic halted;
  logic tick_raw;
  logic tick;

  // Halt masks ticks only, so the prescaler phase is not disturbed
  assign halted = cpu_halted && !run_in_debug;

  acs_prescaler u_clock_divider_select
  (
    .sys_clk              (sys_clk),
    .rst                  (rst),
    .run                  (running),
    .clock_divider_select (clock_divider_select),
    .adc_tick             (tick_raw)
  );

  assign tick = tick_raw && !halted;

  // ****************************************************************
  // Sequencing
  // ****************************************************************
  acs_pkg::acs_state_t     state;
  acs_pkg::acs_state_t     next_state;
  logic [`ACS_CNT_W-1:0]   cyc;
  logic [`ACS_CNT_W-1:0]   next_cyc;
  logic [`ACS_CNT_W-1:0]   conv_len;
  logic [`ACS_CNT_W-1:0]   samp_end;
  logic [6:0]              samp_done;
  logic [6:0]              next_samp_done;
  logic [6:0]              samp_target;
  logic                    next_start;
  logic                    next_ready;
  logic [`ACS_ACCUM_W-1:0] accum;
  logic [`ACS_ACCUM_W-1:0] next_accum;
  logic [`ACS_ACCUM_W-1:0] next_result;
  logic [`ACS_RES_W-1:0]   next_trial;
  logic [`ACS_RES_W-1:0]   sar_mask;
  logic [`ACS_RES_W-1:0]   final_code;
  logic [`ACS_CHAN_W-1:0]  next_chan;
  logic [`ACS_REF_W-1:0]   next_ref;
  logic                    trigger;
  logic                    last_cyc;
  logic                    conv_done;
  logic                    burst_done;

  // Sampling window and total length in converter cycles
  assign samp_end = `ACS_SAMPLE_BASE + `ACS_CNT_W'(sample_delay)
                    + `ACS_CNT_W'(sample_length);
  assign conv_len = `ACS_CONV_BASE + `ACS_CNT_W'(sample_delay)
                    + `ACS_CNT_W'(sample_length);
  // Counts above six are reserved: seven would overflow the 16-bit sum
  assign samp_target = 7'(1) << accumulation_count;
  assign last_cyc    = (state == acs_pkg::ACS_CONV) && (cyc == conv_len - 8'h01);
  assign conv_done   = last_cyc && tick;
  assign burst_done  = conv_done && (samp_done + 7'(1) == samp_target);

  // Bit under trial: one per converter cycle after the sampling window
  assign sar_mask = (state == acs_pkg::ACS_CONV && cyc >= samp_end
                     && cyc < samp_end + 8'h0A)
                    ? (`ACS_RES_W'(10'h200) >> 4'(cyc - samp_end)) : '0;

  // Reduced resolution drops the two lowest bits
  assign final_code = resolution_select ? {sar_trial[9:2], 2'b00} : sar_trial;

  // Writing zero has no effect; disabled converter ignores all triggers
  assign trigger = enable && ((start_write && start_write_value)
                   || (event_start_enable && event_edge));

  // Prescaler sits at zero while idle for a fixed start delay
  assign running = enable && (state != acs_pkg::ACS_IDLE);
  assign busy    = state != acs_pkg::ACS_IDLE;

  always_comb
  begin
    next_state     = state;
    next_cyc       = cyc;
    next_samp_done = samp_done;
    next_start     = start_conversion;
    next_accum     = accum;
    next_result    = result;
    next_trial     = sar_trial;
    next_chan      = active_channel;
    next_ref       = active_reference;
    next_ready     = result_ready_flag;
    // Clear first, so a completion in the same cycle wins
    if (result_read || ready_clear_write)
    begin
      next_ready = 1'b0;
    end
    // Selections follow requests until the first converter edge
    if (state != acs_pkg::ACS_CONV || last_cyc)
    begin
      next_chan = input_channel_select;
      next_ref  = reference_select;
    end
    if (sar_mask != '0 && tick)
    begin
      next_trial = cmp_sync ? sar_trial : (sar_trial & ~sar_mask);
      next_trial = next_trial | (sar_mask >> 1);
    end
    if (!enable)
    begin
      next_state = acs_pkg::ACS_IDLE;
      next_start = 1'b0;
    end
    else
    begin
      case (state)
        acs_pkg::ACS_IDLE:
        begin
          if (trigger)
          begin
            next_start     = 1'b1;
            next_state     = acs_pkg::ACS_WAIT;
            next_samp_done = '0;
            next_accum     = '0;
          end
        end
        acs_pkg::ACS_WAIT:
        begin
          if (tick)
          begin
            // First trial code: top bit set, lower bits clear
            next_state = acs_pkg::ACS_CONV;
            next_cyc   = '0;
            next_trial = `ACS_RES_W'(10'h200);
          end
        end
        acs_pkg::ACS_CONV:
        begin
          if (tick)
          begin
            next_cyc = cyc + 8'h01;
          end
          // Each sample of a burst restarts the count and trial code
          if (conv_done)
          begin
            next_accum     = accum + `ACS_ACCUM_W'(final_code);
            next_samp_done = samp_done + 7'(1);
            next_cyc       = '0;
            next_trial     = `ACS_RES_W'(10'h200);
          end
          if (burst_done)
          begin
            // Right-adjusted: a single 10-bit code fills the low bits
            next_result    = accum + `ACS_ACCUM_W'(final_code);
            next_ready     = 1'b1;
            next_samp_done = '0;
            next_accum     = '0;
            if (continuous_mode_bit && start_conversion)
            begin
              // Free run re-enters sampling with no idle cycle between results
              next_state = acs_pkg::ACS_CONV;
            end
            else
            begin
              next_state = acs_pkg::ACS_IDLE;
              next_start = 1'b0;
            end
          end
        end
        default:
        begin
          next_state = acs_pkg::ACS_IDLE;
        end
      endcase
    end
  end

  assign sample_hold = (state == acs_pkg::ACS_CONV) && (cyc < samp_end);
  assign result_ready_irq = result_ready_flag && result_ready_int_enable
                            && global_int_enable;

  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      state             <= acs_pkg::ACS_IDLE;
      cyc               <= '0;
      samp_done         <= '0;
      start_conversion  <= 1'b0;
      result_ready_flag <= 1'b0;
      accum             <= '0;
      result            <= '0;
      sar_trial         <= '0;
      active_channel    <= '0;
      active_reference  <= '0;
    end
    else
    begin
      state             <= next_state;
      cyc               <= next_cyc;
      samp_done         <= next_samp_done;
      start_conversion  <= next_start;
      result_ready_flag <= next_ready;
      accum             <= next_accum;
      result            <= next_result;
      sar_trial         <= next_trial;
      active_channel    <= next_chan;
      active_reference  <= next_ref;
    end
  end

endmodule : acs_sequencer

/* verification/acs_sequencer_chk.sv */
/*
  Checker of the sequencer ports: start, flag, interrupt, idle channel tracking and halt.
  Assumes a bind onto acs_sequencer, one clock, synchronous reset.
*/
module acs_sequencer_chk
(
  input wire logic         sys_clk,
  input wire logic         rst,
  input wire logic         enable,
  input wire logic         start_write,
  input wire logic         start_write_value,
  input wire logic         event_start_enable,
  input wire logic         event_in,
  input wire logic         result_ready_int_enable,
  input wire logic         global_int_enable,
  input wire logic         ready_clear_write,
  input wire logic         result_read,
  input wire logic         cpu_halted,
  input wire logic         run_in_debug,
  input wire logic [2:0]   accumulation_count,
  input wire logic [4:0]   input_channel_select,
  input wire logic         start_conversion,
  input wire logic         result_ready_flag,
  input wire logic         result_ready_irq,
  input wire logic [15:0]  result,
  input wire logic [4:0]   active_channel,
  input wire logic         sample_hold,
  input wire logic [9:0]   sar_trial,
  input wire logic         busy
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // ********************
  // Port relations
  // ********************
  irq_gating_a:
    assert property (result_ready_irq == (result_ready_flag && result_ready_int_enable
      && global_int_enable)) else $error("irq not flag and enables");
  soft_start_a:
    assert property (enable && start_write && start_write_value && !start_conversion && !busy
      |=> start_conversion) else $error("start write not taken");
  event_start_a:
    assert property (enable && event_start_enable && event_in && !$past(event_in)
      && !start_conversion && !busy |=> start_conversion) else $error("event not taken");
  off_ignore_a:
    assert property (!enable && !start_conversion && !busy |=> !start_conversion)
      else $error("start while disabled");
  flag_clear_a:
    assert property (result_ready_flag && (ready_clear_write || result_read) && !start_conversion
      |=> !result_ready_flag) else $error("flag not cleared");
  flag_keep_a:
    assert property (result_ready_flag && !ready_clear_write && !result_read
      |=> result_ready_flag) else $error("flag lost");
  chan_track_a:
    assert property (!start_conversion && !busy |=> active_channel == $past(input_channel_select))
      else $error("channel not tracked while idle");
  code_range_a:
    assert property ($rose(result_ready_flag) && accumulation_count == 3'h0 |-> result <= 16'h03FF)
      else $error("single result out of range");
  halt_freeze_a:
    assert property (cpu_halted && !run_in_debug && start_conversion |=> $stable(sar_trial))
      else $error("trial moved while halted");
  sample_inside_a:
    assert property (sample_hold |-> start_conversion) else $error("sampling outside conversion");
endmodule : acs_sequencer_chk

/* verification/acs_core_model.sv */
/*
  Behavioural sample-and-hold and comparator facing the sequencer.
  Assumes the sequencer reads the comparator once per converter tick.
*/
module acs_core_model
(
  input wire logic         sys_clk,
  input wire logic         sample_hold,
  input wire logic [9:0]   sar_trial,
  input wire logic [9:0]   level,
  output logic             comparator_in
);
  // ********************
  // Hold and compare
  // ********************
  logic [9:0] held = 10'h000;
  always @(posedge sys_clk)
  begin
    if (sample_hold)
    begin
      held <= level;
    end
  end
  // Keep the trial bit while the held input is at or above it
  assign comparator_in = (held >= sar_trial);
endmodule : acs_core_model

/* verification/acs_sequencer_bench.sv */
/*
  Bench of acs_sequencer: disabled, software, event, free-run and halted runs.
  Assumes acs_core_model and acs_sequencer_chk are compiled alongside.
*/
module acs_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, rst = 1'b1, enable = 1'b0, continuous_mode_bit = 1'b0;
  logic resolution_select = 1'b0, start_write = 1'b0, start_write_value = 1'b0;
  logic event_start_enable = 1'b0, event_in = 1'b0, result_ready_int_enable = 1'b0;
  logic global_int_enable = 1'b0, ready_clear_write = 1'b0, result_read = 1'b0;
  logic cpu_halted = 1'b0, run_in_debug = 1'b0;
  logic [2:0]  accumulation_count = 3'h0, clock_divider_select = 3'h1, reference_select = 3'h0;
  logic [3:0]  sample_delay = 4'h0;
  logic [4:0]  sample_length = 5'h00, input_channel_select = 5'h00, active_channel;
  logic [9:0]  level = 10'h000, sar_trial;
  logic [15:0] result;
  logic [2:0]  active_reference;
  logic comparator_in, start_conversion, result_ready_flag, result_ready_irq, sample_hold, busy;
  int error_cnt = 0, compares = 0, cyc = 0, n, f;

  acs_sequencer u_dut (.sys_clk, .rst, .enable, .continuous_mode_bit, .resolution_select,
    .accumulation_count, .clock_divider_select, .sample_delay, .sample_length,
    .input_channel_select, .reference_select, .start_write, .start_write_value,
    .event_start_enable, .event_in, .result_ready_int_enable, .global_int_enable,
    .ready_clear_write, .result_read, .cpu_halted, .run_in_debug, .comparator_in,
    .start_conversion, .result_ready_flag, .result_ready_irq, .result, .active_channel,
    .active_reference, .sample_hold, .sar_trial, .busy);
  acs_core_model u_core (.sys_clk, .sample_hold, .sar_trial, .level, .comparator_in);

  // ********************
  // Clock, timeout, tasks
  // ********************
  always #10 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 30000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  task wrap_up;
    $display("mismatches %0d compares %0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  task automatic chk(logic [15:0] seen, logic [15:0] exp);
    compares++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask : chk
  task automatic sw(logic v);
    @(posedge sys_clk);
    start_write <= 1'b1;
    start_write_value <= v;
    @(posedge sys_clk);
    start_write <= 1'b0;
  endtask : sw
  task wait_flag;
    n = 0;
    do
    begin
      @(negedge sys_clk);
      n++;
    end while (result_ready_flag !== 1'b1 && n < 3000);
    chk(result_ready_flag, 16'h0001);
  endtask : wait_flag
  // Read pulse or write-one pulse, then the flag must be down
  task automatic clr(logic rd);
    @(posedge sys_clk);
    ready_clear_write <= !rd;
    result_read <= rd;
    @(posedge sys_clk);
    ready_clear_write <= 1'b0;
    result_read <= 1'b0;
    @(negedge sys_clk);
    chk(result_ready_flag, 16'h0000);
  endtask : clr

  // ********************
  // Scenarios
  // ********************
  initial
  begin
    repeat (20) @(posedge sys_clk);
    rst <= 1'b0;
    event_in <= 1'b1;
    sw(1'b1);
    repeat (30) @(negedge sys_clk);
    chk(start_conversion, 16'h0000);
    for (int s = 1; s < 3; s++)
    begin
      @(posedge sys_clk);
      f = 2 << s;
      enable <= 1'b1;
      event_in <= 1'b0;
      clock_divider_select <= 3'(s);
      sample_delay <= 4'h1;
      sample_length <= 5'h02;
      level <= 10'h2A5;
      input_channel_select <= 5'h03;
      reference_select <= 3'(s);
      sw(1'b1);
      n = 0;
      do
      begin
        @(negedge sys_clk);
        n++;
      end while (sample_hold !== 1'b1 && n < 600);
      chk(16'(n), 16'(f / 2 + 2));
      // Selections move during sampling; the running conversion keeps the old ones
      n = 1;
      while (n < 3000)
      begin
        @(posedge sys_clk);
        input_channel_select <= 5'h07;
        reference_select <= 3'h5;
        @(negedge sys_clk);
        if (sample_hold !== 1'b1)
          break;
        n++;
      end
      chk(16'(n), 16'(5 * f));
      chk(16'(active_channel), 16'h0003);
      chk(16'(active_reference), 16'(s));
      wait_flag();
      chk(16'(n), 16'(11 * f));
      chk(start_conversion, 16'h0000);
      chk(busy, 16'h0000);
      chk(result, 16'h02A5);
      chk(result_ready_irq, 16'h0000);
      chk(16'(active_channel), 16'h0007);
      chk(16'(active_reference), 16'h0005);
      clr(s == 2);
    end
    @(posedge sys_clk);
    clock_divider_select <= 3'h1;
    sample_delay <= 4'h0;
    sample_length <= 5'h00;
    accumulation_count <= 3'h2;
    level <= 10'h3FF;
    event_start_enable <= 1'b1;
    result_ready_int_enable <= 1'b1;
    global_int_enable <= 1'b1;
    @(posedge sys_clk);
    event_in <= 1'b1;
    repeat (3) @(negedge sys_clk);
    chk(start_conversion, 16'h0001);
    sw(1'b0);
    @(negedge sys_clk);
    chk(start_conversion, 16'h0001);
    wait_flag();
    chk(result, 16'h0FFC);
    chk(result_ready_irq, 16'h0001);
    clr(1'b0);
    chk(result_ready_irq, 16'h0000);
    @(posedge sys_clk);
    event_in <= 1'b0;
    event_start_enable <= 1'b0;
    accumulation_count <= 3'h0;
    level <= 10'h155;
    resolution_select <= 1'b1;
    continuous_mode_bit <= 1'b1;
    sw(1'b1);
    wait_flag();
    chk(result, 16'h0154);
    clr(1'b1);
    wait_flag();
    chk(result_ready_flag, 16'h0001);
    chk(start_conversion, 16'h0001);
    clr(1'b0);
    @(posedge sys_clk);
    continuous_mode_bit <= 1'b0;
    wait_flag();
    repeat (100) @(negedge sys_clk);
    chk(start_conversion, 16'h0000);
    clr(1'b1);
    @(posedge sys_clk);
    resolution_select <= 1'b0;
    cpu_halted <= 1'b1;
    sw(1'b1);
    repeat (300) @(negedge sys_clk);
    chk(result_ready_flag, 16'h0000);
    chk(start_conversion, 16'h0001);
    chk(busy, 16'h0001);
    @(posedge sys_clk);
    run_in_debug <= 1'b1;
    wait_flag();
    chk(result, 16'h0155);
    wrap_up();
  end
endmodule : acs_sequencer_bench

bind acs_sequencer acs_sequencer_chk u_chk (.sys_clk, .rst, .enable, .start_write,
  .start_write_value, .event_start_enable, .event_in, .result_ready_int_enable,
  .global_int_enable, .ready_clear_write, .result_read, .cpu_halted, .run_in_debug,
  .accumulation_count, .input_channel_select, .start_conversion, .result_ready_flag,
  .result_ready_irq, .result, .active_channel, .sample_hold, .sar_trial, .busy);
